// file: logic/stfe_pkg.sv
/*
  Package for the status transition filter and enable block: register
  selects, live-bit masks, reset values and the command set.
  Assumes a single 25 MHz instrument clock and a command decoder upstream.
*/
package stfe_pkg;
  localparam int unsigned STFE_W = 16;
  localparam int unsigned STFE_SETS = 4;

  // Register set index
  localparam logic [1:0] STFE_SET_OPER = 2'h0;
  localparam logic [1:0] STFE_SET_TRIG = 2'h1;
  localparam logic [1:0] STFE_SET_ARM = 2'h2;
  localparam logic [1:0] STFE_SET_SEQ = 2'h3;

  // Register kind within a set
  localparam logic [2:0] STFE_REG_COND = 3'h0;
  localparam logic [2:0] STFE_REG_RISE = 3'h1;
  localparam logic [2:0] STFE_REG_FALL = 3'h2;
  localparam logic [2:0] STFE_REG_EVENT = 3'h3;
  localparam logic [2:0] STFE_REG_MASK = 3'h4;

  // Live bit positions
  localparam int unsigned STFE_B_SETTLE = 1;
  localparam int unsigned STFE_B_TRIGW = 5;
  localparam int unsigned STFE_B_ARMW = 6;
  localparam int unsigned STFE_B_IDLE = 10;
  localparam int unsigned STFE_B_SEQUENCE_ONE_FLAG = 1;
  localparam int unsigned STFE_B_ARM_LAYER_ONE_FLAG = 1;
  localparam int unsigned STFE_B_ARM_LAYER_TWO_FLAG = 2;

  // Live-bit masks per set: weights 1024+64+32+2, 2, 2, 4+2
  localparam logic [15:0] STFE_LIVE_OPER = 16'h0462;
  localparam logic [15:0] STFE_LIVE_TRIG = 16'h0002;
  localparam logic [15:0] STFE_LIVE_ARM = 16'h0002;
  localparam logic [15:0] STFE_LIVE_SEQ = 16'h0006;

  localparam logic [15:0] STFE_ALL_ONES = 16'hffff;
  localparam logic [15:0] STFE_ZERO = 16'h0000;

  // Command codes from the decoder
  typedef enum logic [2:0] {
    STFE_CMD_NONE = 3'h0,
    STFE_CMD_WRITE = 3'h1,
    STFE_CMD_QUERY = 3'h2,
    STFE_CMD_PRESET = 3'h3,
    STFE_CMD_CLEAR = 3'h4
  } stfe_cmd_t;

  function automatic logic [15:0] stfe_live(input logic [1:0] set);
    logic [15:0] m;
    m = STFE_LIVE_SEQ;
    case (set)
      STFE_SET_OPER: m = STFE_LIVE_OPER;
      STFE_SET_TRIG: m = STFE_LIVE_TRIG;
      STFE_SET_ARM: m = STFE_LIVE_ARM;
      default: m = STFE_LIVE_SEQ;
    endcase
    return m;
  endfunction
endpackage

// file: logic/stfe_set.sv
/*
  One status register set: edge filters, sticky event latch and the
  masked summary. Assumes condition inputs are synchronous to ref_clk.
*/
module stfe_set
  import stfe_pkg::*;
#(
  parameter logic [15:0] LIVE = 16'h0002,
  parameter logic [15:0] MASK_PRESET = 16'h0000
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [15:0] cond,
  input wire logic wr_rise,
  input wire logic wr_fall,
  input wire logic wr_mask,
  input wire logic [15:0] wr_data,
  input wire logic evt_read,
  input wire logic preset,
  input wire logic clear,
  output logic [15:0] rise_r,
  output logic [15:0] fall_r,
  output logic [15:0] mask_r,
  output logic [15:0] event_r,
  output logic [15:0] event_nxt,
  output logic summary_nxt
);
  logic [15:0] cond_q_r;
  logic [15:0] hit;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cond_q_r <= STFE_ZERO;
    end else begin
      cond_q_r <= cond & LIVE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_r <= LIVE;
      fall_r <= STFE_ZERO;
      mask_r <= STFE_ZERO;
    end else if (preset) begin
      rise_r <= LIVE;
      fall_r <= STFE_ZERO;
      mask_r <= MASK_PRESET & LIVE;
    end else begin
      if (wr_rise) rise_r <= wr_data & LIVE;
      if (wr_fall) fall_r <= wr_data & LIVE;
      if (wr_mask) mask_r <= wr_data & LIVE;
    end
  end

  // Condition edges gated by the two filters
  always_comb begin
    hit = (rise_r & (cond & LIVE) & ~cond_q_r)
        | (fall_r & ~(cond & LIVE) & cond_q_r);
    // New hits win over the read-clear, so no edge is lost
    event_nxt = ((evt_read || clear) ? STFE_ZERO : event_r) | (hit & LIVE);
    summary_nxt = |(event_nxt & mask_r);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      event_r <= STFE_ZERO;
    end else begin
      event_r <= event_nxt;
    end
  end

  rise_live_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rise_r & ~LIVE) == STFE_ZERO)
    else $error("Filter holds an unused bit");
  rise_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (|(rise_r & cond & LIVE & ~cond_q_r)) |=> (event_r != STFE_ZERO))
    else $error("Rising edge did not latch");
  fall_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (|(fall_r & ~cond & LIVE & cond_q_r)) |=> (event_r != STFE_ZERO))
    else $error("Falling edge did not latch");
  preset_filter_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    preset |=> (rise_r == LIVE && fall_r == STFE_ZERO))
    else $error("Preset left filters wrong");
endmodule

// file: logic/stfe_top.sv
/*
  Status transition filter and enable block: four register sets
  (operation, trigger, arm, sequence) with query and write commands.
  Assumes an upstream command parser that converts decimal parameters
  to binary and presents one command per cycle; conditions come from
  the trigger model, synchronous to ref_clk.
*/
// Notes on behaviour
// - Operation mask live bits 10, 6, 5, 1.
// - Trigger mask single live bit one.
// - Arm mask single live bit one.
// - Sequence mask live bits two and one.
// - Rising filter all live bits set at reset, preset.
// - Query returns register contents as binary value.
// - Rising condition edge sets event when enabled.
// - Settling start sets operation bit one.
// - Trigger wait start sets operation bit five.
// - Arm wait start sets operation bit six.
// - Entering idle sets operation bit ten.
// - Trigger wait sets trigger event bit one.
// - Entering arm layer sets arm bit one.
// - Layer one, two entry set sequence bits.
// - Falling filter mirrors rising filter bit layout.
// - Falling condition edge sets event when enabled.
// - Only unmasked events drive next summary bit.
// - Event query returns contents, then clears.
module stfe_top
  import stfe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic settling,
  input wire logic trig_wait,
  input wire logic arm_wait,
  input wire logic idle,
  input wire logic arm_layer_one_flag,
  input wire logic arm_layer_two_flag,
  input wire logic [2:0] cmd,
  input wire logic [1:0] cmd_set,
  input wire logic [2:0] cmd_reg,
  input wire logic [15:0] decimal_parameter,
  output logic resp_valid,
  output logic [15:0] resp_data,
  output logic oper_summary,
  output logic [3:0] set_summary
);
  logic [15:0] cond [STFE_SETS];
  logic [15:0] rise [STFE_SETS];
  logic [15:0] fall [STFE_SETS];
  logic [15:0] mask [STFE_SETS];
  logic [15:0] evt [STFE_SETS];
  logic [15:0] evt_nxt [STFE_SETS];
  logic [3:0] sum_nxt;
  logic sequence_one_flag;
  logic is_write;
  logic is_query;
  logic is_preset;
  logic is_clear;
  logic [15:0] sel_val;

  assign is_write = (cmd == STFE_CMD_WRITE);
  assign is_query = (cmd == STFE_CMD_QUERY);
  assign is_preset = (cmd == STFE_CMD_PRESET);
  assign is_clear = (cmd == STFE_CMD_CLEAR);
  assign sequence_one_flag = arm_wait;

  // Condition maps from the trigger model
  always_comb begin
    cond[STFE_SET_OPER] = STFE_ZERO;
    cond[STFE_SET_OPER][STFE_B_SETTLE] = settling;
    cond[STFE_SET_OPER][STFE_B_TRIGW] = trig_wait;
    cond[STFE_SET_OPER][STFE_B_ARMW] = arm_wait;
    cond[STFE_SET_OPER][STFE_B_IDLE] = idle;
    cond[STFE_SET_TRIG] = STFE_ZERO;
    cond[STFE_SET_TRIG][STFE_B_SEQUENCE_ONE_FLAG] = trig_wait;
    cond[STFE_SET_ARM] = STFE_ZERO;
    cond[STFE_SET_ARM][STFE_B_SEQUENCE_ONE_FLAG] = sequence_one_flag;
    cond[STFE_SET_SEQ] = STFE_ZERO;
    cond[STFE_SET_SEQ][STFE_B_ARM_LAYER_ONE_FLAG] = arm_layer_one_flag;
    cond[STFE_SET_SEQ][STFE_B_ARM_LAYER_TWO_FLAG] = arm_layer_two_flag;
  end

  genvar g;
  generate
    for (g = 0; g < STFE_SETS; g++) begin : g_set
      localparam logic [1:0] SET = 2'(g);
      stfe_set #(
        .LIVE(stfe_live(SET)),
        .MASK_PRESET((SET == STFE_SET_OPER) ? STFE_ZERO : STFE_ALL_ONES)
      ) u_set (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .cond(cond[g]),
        .wr_rise(is_write && cmd_set == SET && cmd_reg == STFE_REG_RISE),
        .wr_fall(is_write && cmd_set == SET && cmd_reg == STFE_REG_FALL),
        .wr_mask(is_write && cmd_set == SET && cmd_reg == STFE_REG_MASK),
        .wr_data(decimal_parameter),
        .evt_read(is_query && cmd_set == SET && cmd_reg == STFE_REG_EVENT),
        .preset(is_preset),
        .clear(is_clear),
        .rise_r(rise[g]),
        .fall_r(fall[g]),
        .mask_r(mask[g]),
        .event_r(evt[g]),
        .event_nxt(evt_nxt[g]),
        .summary_nxt(sum_nxt[g])
      );
    end
  endgenerate

  // Read mux; event query reads the value before the clear lands
  always_comb begin
    sel_val = STFE_ZERO;
    case (cmd_reg)
      STFE_REG_COND: sel_val = cond[cmd_set] & stfe_live(cmd_set);
      STFE_REG_RISE: sel_val = rise[cmd_set];
      STFE_REG_FALL: sel_val = fall[cmd_set];
      STFE_REG_EVENT: sel_val = evt[cmd_set];
      STFE_REG_MASK: sel_val = mask[cmd_set];
      default: sel_val = STFE_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_valid <= 1'b0;
      resp_data <= STFE_ZERO;
    end else begin
      resp_valid <= is_query;
      if (is_query) resp_data <= sel_val;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      set_summary <= 4'h0;
      oper_summary <= 1'b0;
    end else begin
      set_summary <= sum_nxt;
      oper_summary <= sum_nxt[STFE_SET_OPER];
    end
  end

  query_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (is_query && cmd_reg == STFE_REG_MASK) |=> (resp_valid && resp_data == $past(sel_val)))
    else $error("Query returned wrong value");
  event_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (is_query && cmd_reg == STFE_REG_EVENT && !settling && !$past(settling))
      |=> (evt[STFE_SET_OPER][STFE_B_SETTLE] == 1'b0 || $past(cmd_set) != STFE_SET_OPER))
    else $error("Event read did not clear");
  summary_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    set_summary[STFE_SET_OPER] |-> |(evt[STFE_SET_OPER] & $past(mask[STFE_SET_OPER])))
    else $error("Masked event raised summary");
  oper_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mask[STFE_SET_OPER] & ~STFE_LIVE_OPER) == STFE_ZERO)
    else $error("Operation mask holds dead bit");
  seq_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mask[STFE_SET_SEQ] & ~STFE_LIVE_SEQ) == STFE_ZERO)
    else $error("Sequence mask holds dead bit");
  idle_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ($rose(idle) && rise[STFE_SET_OPER][STFE_B_IDLE]) |=> evt[STFE_SET_OPER][STFE_B_IDLE])
    else $error("Idle entry not latched");
endmodule

// file: testbench/stfe_host.sv
/*
  Host partner model: issues one status command at a time and collects
  the query answer. Assumes the device samples cmd at each rising edge.
*/
module stfe_host
  import stfe_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resp_valid,
  input wire logic [15:0] resp_data,
  output logic [2:0] cmd,
  output logic [1:0] cmd_set,
  output logic [2:0] cmd_reg,
  output logic [15:0] decimal_parameter
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd = STFE_CMD_NONE;
    cmd_set = 2'h0;
    cmd_reg = 3'h0;
    decimal_parameter = 16'h0000;
  end
  // Value is already the sum of bit weights
  task automatic send(input stfe_cmd_t c, input logic [1:0] s, input logic [2:0] r,
      input logic [15:0] d, output logic [15:0] q, output logic ok);
    int i;
    @(posedge ref_clk);
    cmd <= c;
    cmd_set <= s;
    cmd_reg <= r;
    decimal_parameter <= d;
    @(posedge ref_clk);
    cmd <= STFE_CMD_NONE;
    // Stale data would hide a late sample
    decimal_parameter <= ~d;
    q = 16'h0000;
    ok = (c != STFE_CMD_QUERY);
    for (i = 0; i < 4 && !ok; i++) begin
      #1;
      if (resp_valid === 1'b1) begin
        q = resp_data;
        ok = 1'b1;
      end else begin
        @(posedge ref_clk);
      end
    end
  endtask
endmodule

// file: testbench/status_transition_filter_enable_test.sv
/*
  Testbench for the status block: register rows, reset, edge events,
  masking and clear-on-read. Assumes the host model in stfe_host.sv.
*/
module status_transition_filter_enable_test
  import stfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [1:0] s; logic [2:0] r; logic [15:0] d; logic [15:0] e;} stfe_row_t;
  localparam stfe_row_t ROWS [8] = '{
    '{STFE_SET_OPER, STFE_REG_MASK, 16'hffff, 16'h0462},
    '{STFE_SET_TRIG, STFE_REG_MASK, 16'hffff, 16'h0002},
    '{STFE_SET_ARM, STFE_REG_MASK, 16'hffff, 16'h0002},
    '{STFE_SET_SEQ, STFE_REG_MASK, 16'hffff, 16'h0006},
    '{STFE_SET_OPER, STFE_REG_RISE, 16'h0402, 16'h0402},
    '{STFE_SET_TRIG, STFE_REG_RISE, 16'h0000, 16'h0000},
    '{STFE_SET_OPER, STFE_REG_FALL, 16'h0060, 16'h0060},
    '{STFE_SET_SEQ, STFE_REG_FALL, 16'hffff, 16'h0006}};
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] cnd = 6'h00;
  logic [2:0] cmd;
  logic [1:0] cmd_set;
  logic [2:0] cmd_reg;
  logic [15:0] decimal_parameter;
  logic resp_valid;
  logic [15:0] resp_data;
  logic oper_summary;
  logic [3:0] set_summary;
  int errors = 0;
  int checks = 0;
  always #20 ref_clk = ~ref_clk;
  stfe_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .settling(cnd[0]), .trig_wait(cnd[1]),
    .arm_wait(cnd[2]), .idle(cnd[3]), .arm_layer_one_flag(cnd[4]),
    .arm_layer_two_flag(cnd[5]), .cmd(cmd), .cmd_set(cmd_set), .cmd_reg(cmd_reg),
    .decimal_parameter(decimal_parameter), .resp_valid(resp_valid), .resp_data(resp_data),
    .oper_summary(oper_summary), .set_summary(set_summary));
  stfe_host i_host (.ref_clk(ref_clk), .resp_valid(resp_valid), .resp_data(resp_data),
    .cmd(cmd), .cmd_set(cmd_set), .cmd_reg(cmd_reg), .decimal_parameter(decimal_parameter));
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input stfe_cmd_t c, input logic [1:0] s, input logic [2:0] r,
      input logic [15:0] d, input logic [15:0] e);
    logic [15:0] q;
    logic ok;
    i_host.send(c, s, r, d, q, ok);
    if (ok !== 1'b1) begin
      errors++;
      results();
    end else if (c == STFE_CMD_QUERY) begin
      check(q, e);
    end
  endtask
  task automatic conds(input logic [5:0] v);
    @(posedge ref_clk);
    cnd <= v;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (ROWS[i]) begin
      run(STFE_CMD_WRITE, ROWS[i].s, ROWS[i].r, ROWS[i].d, 16'h0000);
      run(STFE_CMD_QUERY, ROWS[i].s, ROWS[i].r, 16'h0000, ROWS[i].e);
    end
    // Second reset in mid-run
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    run(STFE_CMD_QUERY, STFE_SET_OPER, STFE_REG_RISE, 16'h0000, STFE_LIVE_OPER);
    run(STFE_CMD_QUERY, STFE_SET_OPER, STFE_REG_FALL, 16'h0000, STFE_ZERO);
    run(STFE_CMD_WRITE, STFE_SET_SEQ, STFE_REG_RISE, 16'h0000, 16'h0000);
    run(STFE_CMD_CLEAR, STFE_SET_OPER, STFE_REG_COND, 16'h0000, 16'h0000);
    run(STFE_CMD_QUERY, STFE_SET_SEQ, STFE_REG_RISE, 16'h0000, STFE_ZERO);
    run(STFE_CMD_PRESET, STFE_SET_OPER, STFE_REG_COND, 16'h0000, 16'h0000);
    run(STFE_CMD_QUERY, STFE_SET_SEQ, STFE_REG_RISE, 16'h0000, STFE_LIVE_SEQ);
    run(STFE_CMD_WRITE, STFE_SET_OPER, STFE_REG_MASK, 16'h0462, 16'h0000);
    conds(6'h3f);
    check({12'h000, set_summary}, 16'h000f);
    check({15'h0000, oper_summary}, 16'h0001);
    run(STFE_CMD_QUERY, STFE_SET_OPER, STFE_REG_COND, 16'h0000, 16'h0462);
    run(STFE_CMD_QUERY, STFE_SET_OPER, STFE_REG_EVENT, 16'h0000, 16'h0462);
    run(STFE_CMD_QUERY, STFE_SET_TRIG, STFE_REG_EVENT, 16'h0000, 16'h0002);
    run(STFE_CMD_QUERY, STFE_SET_ARM, STFE_REG_EVENT, 16'h0000, 16'h0002);
    run(STFE_CMD_QUERY, STFE_SET_SEQ, STFE_REG_EVENT, 16'h0000, 16'h0006);
    run(STFE_CMD_QUERY, STFE_SET_OPER, STFE_REG_EVENT, 16'h0000, 16'h0000);
    #1;
    check({12'h000, set_summary}, 16'h0000);
    // Falling edges only, with the operation summary masked
    run(STFE_CMD_WRITE, STFE_SET_OPER, STFE_REG_RISE, 16'h0000, 16'h0000);
    run(STFE_CMD_WRITE, STFE_SET_OPER, STFE_REG_FALL, 16'h0060, 16'h0000);
    run(STFE_CMD_WRITE, STFE_SET_OPER, STFE_REG_MASK, 16'h0000, 16'h0000);
    conds(6'h00);
    check({15'h0000, oper_summary}, 16'h0000);
    run(STFE_CMD_QUERY, STFE_SET_OPER, STFE_REG_EVENT, 16'h0000, 16'h0060);
    results();
  end
endmodule
